// file: cpie_consts.vh
// Constants for the core and peripheral interrupt enable block.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
`ifndef CPIE_CONSTS_VH
`define CPIE_CONSTS_VH

// Register byte offsets
`define CPIE_OFS_CORE_CTRL    5'h00
`define CPIE_OFS_PERIPH_EN1   5'h04
`define CPIE_OFS_PERIPH_FLAGS 5'h08
`define CPIE_OFS_PIN_CHG      5'h0C
`define CPIE_OFS_CORE_STAT    5'h10

// Core control register field positions
`define CPIE_BIT_GLB_EN 7
`define CPIE_BIT_GRP_EN 6
`define CPIE_BIT_TOVIE 5
`define CPIE_BIT_EXTIE 4
`define CPIE_BIT_PCIE  3
`define CPIE_BIT_TOVF  2
`define CPIE_BIT_EXTF  1
`define CPIE_BIT_PCF   0

// Peripheral enable register one, bit 2 unimplemented
`define CPIE_PEN1_IMPL_MASK 8'hFB

// Reset values
`define CPIE_RST_CORE_CTRL  8'h00
`define CPIE_RST_PERIPH_EN1 8'h00

// Handler entry vector
`define CPIE_VECTOR 16'h0004

// Number of monitored pin-change inputs
`define CPIE_PC_PINS 8

`endif

// file: cpie_core_model.sv
// Core model: takes a pending request with a one-cycle pulse when armed.
// Assumes the request is a level driven by the block under test.
module cpie_core_model (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic irq_request_in,
  input  wire logic arm_in,
  output logic      taken_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Never two takes in a row
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) taken_out <= 1'b0;
    else taken_out <= arm_in & irq_request_in & ~taken_out;
  end
endmodule

// file: cpie_irq_ctrl.v
// Core control and peripheral enable one registers with request logic.
// Assumes an Avalon-MM master on the system clock and that event
// sources and core pulses are synchronous one-cycle pulses.
//
// Operation
// - Global enable gates every interrupt request.
// - Peripheral group enable gates peripheral requests.
// - Bit 5 enables basic timer overflow.
// - Bit 2 flags basic timer overflow.
// - Bit 4 enables external pin interrupt.
// - Bit 1 flags external pin event.
// - Bit 3 enables pin-change interrupt.
// - Bit 0 set while any pin flag set.
// - Summary read-only, clears with pin flags.
// - Flags set regardless of any enable.
// - Peripheral bit 7 enables timer gate.
// - Peripheral bit 6 enables converter interrupt.
// - Peripheral bit 5 enables serial receive.
// - Peripheral bit 4 enables serial transmit.
// - Peripheral bit 3 enables sync serial.
// - Peripheral bit 2 always reads zero.
// - Peripheral bit 1 enables period match.
// - Peripheral bit 0 enables wide overflow.
// - All implemented bits reset to zero.
// - Taken interrupt clears global enable, vectors.
// - Return op sets global enable again.
`include "cpie_consts.vh"

module cpie_irq_ctrl #(
  parameter HAS_CONVERTER = 1              // Converter variant present
) (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rstn_in,
  // Avalon-MM slave
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // Core-level event pulses
  input  wire        basic_timer_ovf_in,
  input  wire        ext_pin_event_in,
  input  wire [7:0]  pin_change_event_in,
  // Peripheral flags, levels held by each peripheral
  input  wire [7:0]  periph_flags_in,
  // Processor core side
  input  wire        irq_taken_in,
  input  wire        return_from_handler_op_in,
  output wire        irq_request_out,
  output reg         vector_load_out,
  output reg  [15:0] vector_addr_out
);

  // Register state
  reg        global_irq_enable_r;           // Core control bit 7
  reg        periph_group_irq_enable_r;     // Core control bit 6
  reg        basic_timer_ovf_irq_enable_r;  // Core control bit 5
  reg        ext_pin_irq_enable_r;          // Core control bit 4
  reg        pin_change_irq_enable_r;       // Core control bit 3
  reg        basic_timer_ovf_flag_r;        // Core control bit 2
  reg        ext_pin_irq_flag_r;            // Core control bit 1
  reg [7:0]  per_pin_change_flags_r;        // Per-pin change flags
  reg [7:0]  peripheral_irq_enable_one_r;   // Peripheral enables
  reg        ack_r;                         // Bus answer phase

  // Derived signals
  wire       pin_change_summary_flag;       // Core control bit 0
  wire [7:0] core_irq_control;              // Assembled readback
  wire [7:0] pen1_mask;                     // Implemented enable bits
  wire       core_req;                      // Core-level sources
  wire       periph_req;                    // Peripheral sources
  wire       wr_acc;                        // Accepted write
  wire       rd_acc;                        // Accepted read
  wire [7:0] wbyte;                         // Write data low byte

  // Mask for the converter enable on variants without it
  assign pen1_mask = HAS_CONVERTER ? `CPIE_PEN1_IMPL_MASK
                                   : (`CPIE_PEN1_IMPL_MASK & 8'hBF);

  // Summary flag follows the per-pin flags
  assign pin_change_summary_flag = |per_pin_change_flags_r;

  // Readback of the core control register
  assign core_irq_control = {global_irq_enable_r,
                             periph_group_irq_enable_r,
                             basic_timer_ovf_irq_enable_r,
                             ext_pin_irq_enable_r,
                             pin_change_irq_enable_r,
                             basic_timer_ovf_flag_r,
                             ext_pin_irq_flag_r,
                             pin_change_summary_flag};

  // Request to the core
  assign core_req = (basic_timer_ovf_flag_r & basic_timer_ovf_irq_enable_r)
                  | (ext_pin_irq_flag_r & ext_pin_irq_enable_r)
                  | (pin_change_summary_flag
                     & pin_change_irq_enable_r);
  assign periph_req = |(periph_flags_in & peripheral_irq_enable_one_r);
  assign irq_request_out = global_irq_enable_r
                         & (core_req | (periph_group_irq_enable_r
                                        & periph_req));

  // Bus handshake: one wait cycle, then accept
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign wr_acc = avs_write_in & ack_r;
  assign rd_acc = avs_read_in & ack_r;
  assign wbyte  = avs_byteenable_in[0] ? avs_writedata_in[7:0]
                                       : 8'h00;

  // Answer phase toggles so each access takes two cycles
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
    end
  end

  // Read data register
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if ((avs_read_in | avs_write_in) & ~ack_r) begin
      case (avs_address_in)
        `CPIE_OFS_CORE_CTRL:
          avs_readdata_out <= {24'h000000, core_irq_control};
        `CPIE_OFS_PERIPH_EN1:
          avs_readdata_out <= {24'h000000,
                               peripheral_irq_enable_one_r & pen1_mask};
        `CPIE_OFS_PERIPH_FLAGS:
          avs_readdata_out <= {24'h000000, periph_flags_in};
        `CPIE_OFS_PIN_CHG:
          avs_readdata_out <= {24'h000000, per_pin_change_flags_r};
        `CPIE_OFS_CORE_STAT:
          avs_readdata_out <= {31'h00000000, irq_request_out};
        default:               // Unmapped reads return zero
          avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // Core control register, enables and flags
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      global_irq_enable_r          <= 1'b0;
      periph_group_irq_enable_r    <= 1'b0;
      basic_timer_ovf_irq_enable_r <= 1'b0;
      ext_pin_irq_enable_r         <= 1'b0;
      pin_change_irq_enable_r      <= 1'b0;
      basic_timer_ovf_flag_r       <= 1'b0;
      ext_pin_irq_flag_r           <= 1'b0;
    end else begin
      // Software write; flags are write-clear by writing zero
      if (wr_acc && avs_address_in == `CPIE_OFS_CORE_CTRL &&
          avs_byteenable_in[0]) begin
        global_irq_enable_r          <= wbyte[`CPIE_BIT_GLB_EN];
        periph_group_irq_enable_r    <= wbyte[`CPIE_BIT_GRP_EN];
        basic_timer_ovf_irq_enable_r <= wbyte[`CPIE_BIT_TOVIE];
        ext_pin_irq_enable_r         <= wbyte[`CPIE_BIT_EXTIE];
        pin_change_irq_enable_r      <= wbyte[`CPIE_BIT_PCIE];
        basic_timer_ovf_flag_r       <= basic_timer_ovf_flag_r
                                      & wbyte[`CPIE_BIT_TOVF];
        ext_pin_irq_flag_r           <= ext_pin_irq_flag_r
                                      & wbyte[`CPIE_BIT_EXTF];
      end
      // Core entry clears global enable, return sets it
      if (irq_taken_in && irq_request_out) begin
        global_irq_enable_r <= 1'b0;
      end else if (return_from_handler_op_in) begin
        global_irq_enable_r <= 1'b1;
      end
      // Events win over clears, set regardless of enables
      if (basic_timer_ovf_in) begin
        basic_timer_ovf_flag_r <= 1'b1;
      end
      if (ext_pin_event_in) begin
        ext_pin_irq_flag_r <= 1'b1;
      end
    end
  end

  // Per-pin change flags, write one to clear, set wins
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      per_pin_change_flags_r <= 8'h00;
    end else if (wr_acc && avs_address_in == `CPIE_OFS_PIN_CHG &&
                 avs_byteenable_in[0]) begin
      per_pin_change_flags_r <= (per_pin_change_flags_r & ~wbyte)
                              | pin_change_event_in;
    end else begin
      per_pin_change_flags_r <= per_pin_change_flags_r
                              | pin_change_event_in;
    end
  end

  // Peripheral enable register one
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      peripheral_irq_enable_one_r <= `CPIE_RST_PERIPH_EN1;
    end else if (wr_acc && avs_address_in == `CPIE_OFS_PERIPH_EN1 &&
                 avs_byteenable_in[0]) begin
      peripheral_irq_enable_one_r <= wbyte & pen1_mask;
    end
  end

  // Vector load pulse to the core on entry
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vector_load_out <= 1'b0;
      vector_addr_out <= 16'h0000;
    end else begin
      vector_load_out <= irq_taken_in & irq_request_out;
      if (irq_taken_in && irq_request_out) begin
        vector_addr_out <= `CPIE_VECTOR;
      end
    end
  end

endmodule

// file: cpie_irq_monitor.sv
// Checker for the interrupt enable block, watching its ports only.
// Assumes one clock and an asynchronous active-low reset.
`include "cpie_consts.vh"
module cpie_irq_monitor (
  // Clock and reset
  input wire        core_clk_in,
  input wire        rstn_in,
  // Register bus
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  // Core side
  input wire        irq_taken_in,
  input wire        irq_request_out,
  input wire        vector_load_out,
  input wire [15:0] vector_addr_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // New bus request and an accepted take
  sequence s_req; $rose(avs_read_in | avs_write_in); endsequence
  sequence s_take; irq_taken_in && irq_request_out; endsequence
  property p_wait; s_req |-> avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("no wait cycle");
  property p_ack;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_ack: assert property (p_ack) else $error("wait too long");
  property p_glb; s_take |=> !irq_request_out; endproperty
  a_glb: assert property (p_glb) else $error("request stays");
  property p_vec; s_take |=> vector_load_out; endproperty
  a_vec: assert property (p_vec) else $error("no vector load");
  property p_vsrc; vector_load_out |-> $past(irq_taken_in && irq_request_out);
  endproperty
  a_vsrc: assert property (p_vsrc) else $error("stray load");
  property p_vadr; vector_load_out |-> vector_addr_out == `CPIE_VECTOR;
  endproperty
  a_vadr: assert property (p_vadr) else $error("bad vector");
  property p_rdz;
    avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("upper bits set");
  property p_rst; $rose(rstn_in) |-> !irq_request_out && !vector_load_out;
  endproperty
  a_rst: assert property (p_rst) else $error("live after reset");
endmodule

bind cpie_irq_ctrl cpie_irq_monitor u_mon (.core_clk_in(core_clk_in),
  .rstn_in(rstn_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_taken_in(irq_taken_in),
  .irq_request_out(irq_request_out), .vector_load_out(vector_load_out),
  .vector_addr_out(vector_addr_out));

// file: cpie_tb.sv
// Bench: bus tasks, event pulses and a core model around the block.
// Assumes one wait cycle per access, reads sampled at the accept edge.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, tov = 0, ext = 0, ret = 0, arm = 0;
  logic take, wait_r, req, vld;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat;
  logic [7:0] pc = 0, pf = 0, got;
  logic [15:0] vadr;
  int fails = 0, checks_done = 0, i;
  always #25 clk = ~clk;
  cpie_irq_ctrl dut (.core_clk_in(clk), .rstn_in(rstn), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_r), .basic_timer_ovf_in(tov),
    .ext_pin_event_in(ext), .pin_change_event_in(pc),
    .periph_flags_in(pf), .irq_taken_in(take),
    .return_from_handler_op_in(ret), .irq_request_out(req),
    .vector_load_out(vld), .vector_addr_out(vadr));
  cpie_core_model core (.core_clk_in(clk), .rstn_in(rstn),
    .irq_request_in(req), .arm_in(arm), .taken_out(take));
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    logic s;
    n = 0;
    s = 1'b1;
    @(posedge clk);
    rd <= !w; wr <= w; adr <= a; wd <= {24'h0, d};
    // Settled values seen mid-cycle stand at the next rising edge
    do begin
      @(negedge clk);
      s = wait_r;
      got = rdat[7:0];
      @(posedge clk);
      n++;
    end while (s !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, got}, {8'h00, e});
  endtask
  // Event pulse: 0 timer, 1 external pin, 2 pin change
  task automatic fire(input int k);
    @(posedge clk);
    tov <= (k == 0); ext <= (k == 1); pc <= {4'h0, k == 2, 3'h0};
    @(posedge clk);
    tov <= 1'b0; ext <= 1'b0; pc <= 8'h00;
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask
  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up;
  end
  initial begin
    do_reset;
    rchk(5'h00, 8'h00);
    acc(1'b1, 5'h04, 8'hFF);
    rchk(5'h04, 8'hFB);
    for (i = 0; i < 3; i++) fire(i);
    rchk(5'h00, 8'h07);
    rchk(5'h10, 8'h00);
    acc(1'b1, 5'h00, 8'h00);
    rchk(5'h00, 8'h01);
    acc(1'b1, 5'h0C, 8'hFF);
    rchk(5'h00, 8'h00);
    for (i = 0; i < 3; i++) begin
      acc(1'b1, 5'h00, 8'h20 >> i);
      fire(i);
      rchk(5'h10, 8'h00);
      acc(1'b1, 5'h00, 8'h80 | (8'h20 >> i) | (8'h04 >> i));
      rchk(5'h10, 8'h01);
      acc(1'b1, 5'h00, 8'h00);
      acc(1'b1, 5'h0C, 8'hFF);
      rchk(5'h10, 8'h00);
    end
    for (i = 0; i < 8; i++) begin
      pf <= 8'h01 << i;
      acc(1'b1, 5'h04, 8'h01 << i);
      acc(1'b1, 5'h00, 8'h80);
      rchk(5'h10, 8'h00);
      acc(1'b1, 5'h00, 8'hC0);
      rchk(5'h10, {7'h0, i != 2});
    end
    pf <= 8'h01;
    acc(1'b1, 5'h04, 8'h01);
    arm <= 1'b1;
    i = 0;
    while (vld !== 1'b1 && i < 20) begin @(negedge clk); i++; end
    @(posedge clk);
    arm <= 1'b0;
    chk(vadr, 16'h0004);
    rchk(5'h00, 8'h40);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    rchk(5'h00, 8'hC0);
    rchk(5'h14, 8'h00);
    do_reset;
    rchk(5'h00, 8'h00);
    rchk(5'h04, 8'h00);
    wrap_up;
  end
endmodule
